// [rtl/bnw_pkg.sv]
// constants, types and helpers for the bridge bus number and i/o window registers
// What this block does
// - header layout code reads constant 01h
// - upstream bus number, read-write, resets 00h
// - downstream bus number, read-write, resets 00h
// - highest bus below, read-write, resets 00h
// - downstream latency timer hard-wired 00h
// - i/o capability nibbles read 1h
// - i/o base bits 15:12 writable, reset 0h
// - base low twelve address bits zero
// - i/o limit bits 15:12 writable, reset 0h
// - limit low twelve address bits all ones
// - upper halves from separate registers
// - forward i/o inside inclusive base..limit
package bnw_pkg;
    // ----------------------------------------
    // offsets
    // ----------------------------------------
    localparam int unsigned BNW_AW = 12;
    localparam logic [11:0] BNW_OFF_HDR = 12'h00c;
    localparam logic [11:0] BNW_OFF_BUS = 12'h018;
    localparam logic [11:0] BNW_OFF_IO = 12'h01c;
    localparam logic [11:0] BNW_OFF_IOUP = 12'h030;
    // ----------------------------------------
    // fields and reset values
    // ----------------------------------------
    localparam int unsigned BNW_HDR_LSB = 16;
    localparam int unsigned BNW_UPS_LSB = 0;
    localparam int unsigned BNW_DNS_LSB = 8;
    localparam int unsigned BNW_HIB_LSB = 16;
    localparam int unsigned BNW_LAT_LSB = 24;
    localparam int unsigned BNW_IOBC_LSB = 0;
    localparam int unsigned BNW_IOB_LSB = 4;
    localparam int unsigned BNW_IOLC_LSB = 8;
    localparam int unsigned BNW_IOL_LSB = 12;
    localparam int unsigned BNW_UPB_LSB = 0;
    localparam int unsigned BNW_UPL_LSB = 16;
    localparam logic [7:0] BNW_HDR_CODE = 8'h01;
    localparam logic [7:0] BNW_LAT_VAL = 8'h00;
    localparam logic [3:0] BNW_IO_CAP = 4'h1;
    localparam logic [7:0] BNW_BUS_RST = 8'h00;
    localparam logic [3:0] BNW_NIB_RST = 4'h0;
    localparam logic [15:0] BNW_UP_RST = 16'h0000;
    localparam logic [11:0] BNW_IO_LOW_BASE = 12'h000;
    localparam logic [11:0] BNW_IO_LOW_LIM = 12'hfff;
    localparam logic [31:0] BNW_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        BNW_SEL_NONE = 3'b000,
        BNW_SEL_HDR = 3'b001,
        BNW_SEL_BUS = 3'b010,
        BNW_SEL_IO = 3'b011,
        BNW_SEL_IOUP = 3'b100
    } bnw_sel_e;

    function automatic bnw_sel_e bnw_decode(input logic [11:0] addr);
        case (addr)
            BNW_OFF_HDR: bnw_decode = BNW_SEL_HDR;
            BNW_OFF_BUS: bnw_decode = BNW_SEL_BUS;
            BNW_OFF_IO: bnw_decode = BNW_SEL_IO;
            BNW_OFF_IOUP: bnw_decode = BNW_SEL_IOUP;
            default: bnw_decode = BNW_SEL_NONE;
        endcase
    endfunction : bnw_decode

    function automatic logic [7:0] bnw_merge8(input logic [7:0] old, input logic [7:0] wd,
                                             input logic en);
        bnw_merge8 = en ? wd : old;
    endfunction : bnw_merge8
endpackage : bnw_pkg

// [rtl/bnw_apb_port.sv]
// apb access phase sequencer with one wait state
`timescale 1ns/1ns
module bnw_apb_port
    import bnw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    output logic pready,
    output logic capture,
    output logic commit
);
    typedef enum logic [0:0] {
        BNW_ST_IDLE = 1'b0,
        BNW_ST_ACK = 1'b1
    } bnw_apb_e;
    typedef struct packed {
        bnw_apb_e st;
    } bnw_apb_s;

    bnw_apb_s q;
    bnw_apb_s next_q;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    // capture on first access cycle, commit on the pready edge
    assign capture = psel && penable && (q.st == BNW_ST_IDLE);
    assign commit = psel && penable && (q.st == BNW_ST_ACK);
    assign pready = q.st[0];

    always_comb
    begin
        next_q = q;
        case (q.st)
            BNW_ST_IDLE: if (capture) next_q.st = BNW_ST_ACK;
            BNW_ST_ACK: next_q.st = BNW_ST_IDLE;
            default: next_q.st = BNW_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn) q <= '{st: BNW_ST_IDLE};
        else q <= next_q;
    end

    chk_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("pready held longer than one cycle");
    chk_ready_follows: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready) else $error("pready late");
endmodule : bnw_apb_port

// [rtl/bnw_io_decode.sv]
// i/o window bound forming and forward decision
`timescale 1ns/1ns
module bnw_io_decode
    import bnw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic io_req,
    input wire logic [31:0] io_addr,
    input wire logic [3:0] base_nib,
    input wire logic [3:0] lim_nib,
    input wire logic [15:0] base_up,
    input wire logic [15:0] lim_up,
    output logic io_fwd_valid,
    output logic io_fwd
);
    typedef struct packed {
        logic valid;
        logic fwd;
    } bnw_dec_s;

    bnw_dec_s q;
    bnw_dec_s next_q;
    logic [31:0] lo;
    logic [31:0] hi;

    // ----------------------------------------
    // bounds and compare
    // ----------------------------------------
    assign lo = {base_up, base_nib, BNW_IO_LOW_BASE};
    assign hi = {lim_up, lim_nib, BNW_IO_LOW_LIM};

    always_comb
    begin
        next_q = q;
        next_q.valid = io_req;
        // a limit below the base yields an empty window
        next_q.fwd = io_req && (io_addr >= lo) && (io_addr <= hi);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn) q <= '{valid: 1'b0, fwd: 1'b0};
        else q <= next_q;
    end

    assign io_fwd_valid = q.valid;
    assign io_fwd = q.fwd;

    chk_base_aligned: assert property (@(posedge pclk) disable iff (!presetn)
        io_req && io_addr[31:12] == lo[31:12] |=> io_fwd || !io_fwd_valid
            || ($past(io_addr) > $past(hi))) else $error("base block not forwarded");
    chk_limit_top: assert property (@(posedge pclk) disable iff (!presetn)
        io_req && io_addr[31:12] == hi[31:12] && io_addr >= lo |=> io_fwd)
        else $error("limit block not fully forwarded");
    chk_fwd_range: assert property (@(posedge pclk) disable iff (!presetn)
        io_req |=> io_fwd == (($past(io_addr) >= $past(lo)) && ($past(io_addr) <= $past(hi))))
        else $error("forward decision wrong");
endmodule : bnw_io_decode

// [rtl/bnw_regs.sv]
// bridge bus number and i/o window register bank with apb slave
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
module bnw_regs
    import bnw_pkg::*;
#(
    parameter int unsigned AW = BNW_AW
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic io_req,
    input wire logic [31:0] io_addr,
    output logic io_fwd_valid,
    output logic io_fwd,
    output logic [7:0] upstream_bus_number,
    output logic [7:0] downstream_bus_number,
    output logic [7:0] highest_bus_below
);
    import bnw_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] ups;
        logic [7:0] dns;
        logic [7:0] hib;
        logic [3:0] iob;
        logic [3:0] iol;
        logic [15:0] iob_up;
        logic [15:0] iol_up;
        logic [31:0] rdata;
        logic err;
    } bnw_regs_s;

    localparam bnw_regs_s BNW_RST = '{
        ups: BNW_BUS_RST,
        dns: BNW_BUS_RST,
        hib: BNW_BUS_RST,
        iob: BNW_NIB_RST,
        iol: BNW_NIB_RST,
        iob_up: BNW_UP_RST,
        iol_up: BNW_UP_RST,
        rdata: BNW_ZERO,
        err: 1'b0
    };

    bnw_regs_s q;
    bnw_regs_s next_q;
    logic capture;
    logic commit;
    logic wr;
    bnw_sel_e sel;
    logic [31:0] rd_word;

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    bnw_apb_port u_port (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pready(pready),
        .capture(capture),
        .commit(commit)
    );

    assign sel = bnw_decode(paddr[11:0]);
    assign wr = commit && pwrite;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb
    begin
        rd_word = BNW_ZERO;
        case (sel)
            BNW_SEL_HDR:
            begin
                rd_word[BNW_HDR_LSB +: 8] = BNW_HDR_CODE;
            end
            BNW_SEL_BUS:
            begin
                rd_word[BNW_UPS_LSB +: 8] = q.ups;
                rd_word[BNW_DNS_LSB +: 8] = q.dns;
                rd_word[BNW_HIB_LSB +: 8] = q.hib;
                rd_word[BNW_LAT_LSB +: 8] = BNW_LAT_VAL;
            end
            BNW_SEL_IO:
            begin
                rd_word[BNW_IOBC_LSB +: 4] = BNW_IO_CAP;
                rd_word[BNW_IOB_LSB +: 4] = q.iob;
                rd_word[BNW_IOLC_LSB +: 4] = BNW_IO_CAP;
                rd_word[BNW_IOL_LSB +: 4] = q.iol;
            end
            BNW_SEL_IOUP:
            begin
                rd_word[BNW_UPB_LSB +: 16] = q.iob_up;
                rd_word[BNW_UPL_LSB +: 16] = q.iol_up;
            end
            default:
            begin
                rd_word = BNW_ZERO;
            end
        endcase
    end

    // ----------------------------------------
    // register update
    // ----------------------------------------
    always_comb
    begin
        next_q = q;
        if (capture)
        begin
            // read data and error register on the same edge that raises pready
            next_q.rdata = pwrite ? BNW_ZERO : rd_word;
            next_q.err = (sel == BNW_SEL_NONE);
        end
        if (wr)
        begin
            case (sel)
                BNW_SEL_BUS:
                begin
                    next_q.ups = bnw_merge8(q.ups, pwdata[BNW_UPS_LSB +: 8], pstrb[0]);
                    next_q.dns = bnw_merge8(q.dns, pwdata[BNW_DNS_LSB +: 8], pstrb[1]);
                    next_q.hib = bnw_merge8(q.hib, pwdata[BNW_HIB_LSB +: 8], pstrb[2]);
                    // latency byte has no storage, lane 3 dropped
                end
                BNW_SEL_IO:
                begin
                    // only the upper nibbles store, capability nibbles stay constant
                    if (pstrb[0]) next_q.iob = pwdata[BNW_IOB_LSB +: 4];
                    if (pstrb[1]) next_q.iol = pwdata[BNW_IOL_LSB +: 4];
                end
                BNW_SEL_IOUP:
                begin
                    next_q.iob_up[7:0] = bnw_merge8(q.iob_up[7:0], pwdata[7:0], pstrb[0]);
                    next_q.iob_up[15:8] = bnw_merge8(q.iob_up[15:8], pwdata[15:8], pstrb[1]);
                    next_q.iol_up[7:0] = bnw_merge8(q.iol_up[7:0], pwdata[23:16], pstrb[2]);
                    next_q.iol_up[15:8] = bnw_merge8(q.iol_up[15:8], pwdata[31:24], pstrb[3]);
                end
                default:
                begin
                    // header word is constant, unmapped writes vanish
                    next_q = next_q;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn) q <= BNW_RST;
        else q <= next_q;
    end

    // ----------------------------------------
    // window decision
    // ----------------------------------------
    bnw_io_decode u_dec (
        .pclk(pclk),
        .presetn(presetn),
        .io_req(io_req),
        .io_addr(io_addr),
        .base_nib(q.iob),
        .lim_nib(q.iol),
        .base_up(q.iob_up),
        .lim_up(q.iol_up),
        .io_fwd_valid(io_fwd_valid),
        .io_fwd(io_fwd)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata = q.rdata;
    assign pslverr = q.err;
    assign upstream_bus_number = q.ups;
    assign downstream_bus_number = q.dns;
    assign highest_bus_below = q.hib;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking bnw_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_header_code: assert property (
        capture && !pwrite && sel == BNW_SEL_HDR
        |=> pready && prdata[BNW_HDR_LSB +: 8] == BNW_HDR_CODE)
        else $error("header layout code not 01h");

    chk_upstream_write: assert property (
        wr && sel == BNW_SEL_BUS && pstrb[0]
        |=> upstream_bus_number == $past(pwdata[7:0]))
        else $error("upstream bus number not written");

    chk_downstream_write: assert property (
        wr && sel == BNW_SEL_BUS && pstrb[1]
        |=> downstream_bus_number == $past(pwdata[15:8]))
        else $error("downstream bus number not written");

    chk_highest_write: assert property (
        wr && sel == BNW_SEL_BUS && pstrb[2]
        |=> highest_bus_below == $past(pwdata[23:16]))
        else $error("highest bus below not written");

    chk_bus_hold: assert property (
        !wr |=> $stable(upstream_bus_number) && $stable(downstream_bus_number)
            && $stable(highest_bus_below))
        else $error("bus number changed without a write");

    chk_latency_zero: assert property (
        capture && !pwrite && sel == BNW_SEL_BUS
        |=> prdata[BNW_LAT_LSB +: 8] == BNW_LAT_VAL)
        else $error("latency timer not 00h");

    chk_io_cap: assert property (
        capture && !pwrite && sel == BNW_SEL_IO
        |=> prdata[BNW_IOBC_LSB +: 4] == BNW_IO_CAP
            && prdata[BNW_IOLC_LSB +: 4] == BNW_IO_CAP)
        else $error("i/o capability nibble not 1h");

    chk_base_write: assert property (
        wr && sel == BNW_SEL_IO && pstrb[0]
        |=> q.iob == $past(pwdata[7:4]))
        else $error("i/o base nibble not written");

    chk_limit_write: assert property (
        wr && sel == BNW_SEL_IO && pstrb[1]
        |=> q.iol == $past(pwdata[15:12]))
        else $error("i/o limit nibble not written");

    chk_upper_write: assert property (
        wr && sel == BNW_SEL_IOUP && pstrb == 4'hf
        |=> {q.iol_up, q.iob_up} == $past(pwdata))
        else $error("upper window halves not written");

    chk_readback: assert property (
        // an idle cycle and a setup cycle sit between the write and the next capture
        wr && sel == BNW_SEL_IO && pstrb == 4'hf ##1 !psel
        ##2 capture && !pwrite && sel == BNW_SEL_IO
        |=> prdata[15:0] == {$past(pwdata[15:12], 4), BNW_IO_CAP,
                             $past(pwdata[7:4], 4), BNW_IO_CAP})
        else $error("i/o word readback wrong");

    chk_unmapped_err: assert property (
        capture && sel == BNW_SEL_NONE |=> pready && pslverr)
        else $error("unmapped access not flagged");

    chk_mapped_ok: assert property (
        capture && sel != BNW_SEL_NONE |=> pready && !pslverr)
        else $error("mapped access flagged as error");

    // ----------------------------------------
    // checks on masked lanes and read words
    // ----------------------------------------
    chk_upstream_keep: assert property (
        wr && sel == BNW_SEL_BUS && !pstrb[0]
        |=> $stable(upstream_bus_number))
        else $error("upstream bus number changed by a masked lane");

    chk_downstream_keep: assert property (
        wr && sel == BNW_SEL_BUS && !pstrb[1]
        |=> $stable(downstream_bus_number))
        else $error("downstream bus number changed by a masked lane");

    chk_highest_keep: assert property (
        wr && sel == BNW_SEL_BUS && !pstrb[2]
        |=> $stable(highest_bus_below))
        else $error("highest bus below changed by a masked lane");

    chk_latency_drop: assert property (
        wr && sel == BNW_SEL_BUS && pstrb == 4'h8
        |=> $stable(q))
        else $error("latency byte write changed state");

    chk_const_drop: assert property (
        wr && (sel == BNW_SEL_HDR || sel == BNW_SEL_NONE)
        |=> $stable(q))
        else $error("constant or unmapped write changed state");

    chk_base_keep: assert property (
        wr && sel == BNW_SEL_IO && !pstrb[0]
        |=> $stable(q.iob))
        else $error("i/o base nibble changed by a masked lane");

    chk_limit_keep: assert property (
        wr && sel == BNW_SEL_IO && !pstrb[1]
        |=> $stable(q.iol))
        else $error("i/o limit nibble changed by a masked lane");

    chk_io_hold: assert property (
        !(wr && sel == BNW_SEL_IO)
        |=> $stable(q.iob) && $stable(q.iol))
        else $error("i/o window nibble changed without a write");

    chk_upper_hold: assert property (
        !(wr && sel == BNW_SEL_IOUP)
        |=> $stable(q.iob_up) && $stable(q.iol_up))
        else $error("upper window half changed without a write");

    chk_bus_readback: assert property (
        capture && !pwrite && sel == BNW_SEL_BUS
        |=> prdata[23:0] == {$past(q.hib), $past(q.dns), $past(q.ups)})
        else $error("bus number word readback wrong");

    chk_io_readback: assert property (
        capture && !pwrite && sel == BNW_SEL_IO
        |=> prdata[BNW_IOL_LSB +: 4] == $past(q.iol) && prdata[BNW_IOB_LSB +: 4] == $past(q.iob))
        else $error("i/o nibble readback wrong");

    chk_upper_readback: assert property (
        capture && !pwrite && sel == BNW_SEL_IOUP
        |=> prdata == {$past(q.iol_up), $past(q.iob_up)})
        else $error("upper window readback wrong");

    chk_io_high_zero: assert property (
        capture && !pwrite && sel == BNW_SEL_IO
        |=> prdata[31:16] == 16'h0000)
        else $error("i/o word upper half not zero");

    chk_write_rdata_zero: assert property (
        capture && pwrite
        |=> prdata == BNW_ZERO)
        else $error("read data not zero on a write");

    // software may look at the answer late, so it must not drift
    chk_rdata_hold: assert property (
        !capture
        |=> $stable(prdata) && $stable(pslverr))
        else $error("read data or error moved without an access");
endmodule : bnw_regs

// [tb/bnw_regs_test.sv]
// self-checking bench for the bus number and i/o window register bank
`timescale 1ns/1ns
module bnw_regs_test;
    import bnw_pkg::*;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic io_req = 1'b0;
    logic [31:0] io_addr = 32'h0000_0000;
    logic io_fwd_valid;
    logic io_fwd;
    logic [7:0] upstream_bus_number;
    logic [7:0] downstream_bus_number;
    logic [7:0] highest_bus_below;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [31:0] io_a [6] = '{32'h0001_1fff, 32'h0001_2000, 32'h0001_3abc, 32'h0001_3fff,
                              32'h0001_4000, 32'h0002_3000};
    logic io_e [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

    always #4 pclk = ~pclk;

    bnw_regs i_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .io_req(io_req),
        .io_addr(io_addr),
        .io_fwd_valid(io_fwd_valid),
        .io_fwd(io_fwd),
        .upstream_bus_number(upstream_bus_number),
        .downstream_bus_number(downstream_bus_number),
        .highest_bus_below(highest_bus_below)
    );

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic close_out;
        if (n_mismatch == 0 && checks_done > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
        checks_done++;
        if (seen !== expd)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, expd, seen);
        end
    endtask : check

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] expd,
                         input logic experr);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        check(what, rd, expd);
        check({what, " err"}, {31'h0, err}, {31'h0, experr});
    endtask : rdchk

    // one-cycle request, answer looked at in the cycle after it is taken
    task automatic io_chk(input logic [31:0] a, input logic expd);
        @(posedge pclk);
        io_req <= 1'b1;
        io_addr <= a;
        @(posedge pclk);
        io_req <= 1'b0;
        @(posedge pclk);
        check("io valid", {31'h0, io_fwd_valid}, 32'h0000_0001);
        check("io fwd", {31'h0, io_fwd}, {31'h0, expd});
    endtask : io_chk

    task automatic defaults;
        rdchk("hdr rst", BNW_OFF_HDR, 32'h0001_0000, 1'b0);
        rdchk("bus rst", BNW_OFF_BUS, 32'h0000_0000, 1'b0);
        rdchk("io rst", BNW_OFF_IO, 32'h0000_0101, 1'b0);
        rdchk("ioup rst", BNW_OFF_IOUP, 32'h0000_0000, 1'b0);
        check("ups port", {24'h0, upstream_bus_number}, 32'h0000_0000);
        check("dns port", {24'h0, downstream_bus_number}, 32'h0000_0000);
        check("hib port", {24'h0, highest_bus_below}, 32'h0000_0000);
    endtask : defaults

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        defaults();
        // reset window is 0..fff, so a low address forwards
        io_chk(32'h0000_0800, 1'b1);
        io_chk(32'h0000_1000, 1'b0);
        apb(1'b1, BNW_OFF_BUS, 32'hffcc_bbaa, 4'hf);
        rdchk("bus wr", BNW_OFF_BUS, 32'h00cc_bbaa, 1'b0);
        check("ups port", {24'h0, upstream_bus_number}, 32'h0000_00aa);
        check("dns port", {24'h0, downstream_bus_number}, 32'h0000_00bb);
        check("hib port", {24'h0, highest_bus_below}, 32'h0000_00cc);
        // single lanes: one writable byte, then only the hard-wired byte
        apb(1'b1, BNW_OFF_BUS, 32'h0000_0055, 4'h1);
        rdchk("bus lane", BNW_OFF_BUS, 32'h00cc_bb55, 1'b0);
        apb(1'b1, BNW_OFF_BUS, 32'hff00_0000, 4'h8);
        rdchk("lat wr", BNW_OFF_BUS, 32'h00cc_bb55, 1'b0);
        apb(1'b1, BNW_OFF_HDR, 32'hffff_ffff, 4'hf);
        rdchk("hdr wr", BNW_OFF_HDR, 32'h0001_0000, 1'b0);
        apb(1'b1, BNW_OFF_IO, 32'hffff_ffff, 4'hf);
        rdchk("io ones", BNW_OFF_IO, 32'h0000_f1f1, 1'b0);
        // unmapped and misaligned places answer with an error
        rdchk("unmapped", 12'h040, 32'h0000_0000, 1'b1);
        rdchk("misalign", 12'h019, 32'h0000_0000, 1'b1);
        apb(1'b1, 12'h040, 32'hffff_ffff, 4'hf);
        check("unmapped wr err", {31'h0, err}, 32'h0000_0001);
        // window 0001_2000 .. 0001_3fff
        apb(1'b1, BNW_OFF_IO, 32'h0000_3020, 4'hf);
        apb(1'b1, BNW_OFF_IOUP, 32'h0001_0001, 4'hf);
        rdchk("io prog", BNW_OFF_IO, 32'h0000_3121, 1'b0);
        rdchk("ioup prog", BNW_OFF_IOUP, 32'h0001_0001, 1'b0);
        for (int i = 0; i < 6; i++)
        begin
            io_chk(io_a[i], io_e[i]);
        end
        // limit below base: nothing goes through
        apb(1'b1, BNW_OFF_IO, 32'h0000_1020, 4'hf);
        io_chk(32'h0001_2000, 1'b0);
        // partial strobes touch only their own lanes
        apb(1'b1, BNW_OFF_IO, 32'h0000_a0b0, 4'h2);
        rdchk("io lane", BNW_OFF_IO, 32'h0000_a121, 1'b0);
        apb(1'b1, BNW_OFF_IOUP, 32'hffff_0005, 4'h3);
        rdchk("ioup lane", BNW_OFF_IOUP, 32'h0001_0005, 1'b0);
        // second reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        defaults();
        close_out();
    end
endmodule : bnw_regs_test
